// ==== bench/arvc_host_model.sv ====
// host model: drives the register bus of the configuration bank
`timescale 1ns/100ps
module arvc_host_model
    import arvc_pkg::*;
(
    input  wire logic               clk,       // bus clock
    output logic      [ARVC_AW-1:0] reg_addr,  // register address
    output logic      [ARVC_DW-1:0] reg_wdata, // write data
    output logic                    reg_wr,    // write strobe
    output logic                    reg_rd,    // read strobe
    input  wire logic [ARVC_DW-1:0] reg_rdata  // read data
);
    // bus is quiet from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end
    // write; strobe stays high so another access can follow with no gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr   <= 1'b1;
        reg_rd   <= 1'b0;
        reg_addr <= a;
        if (a == ARVC_RATE_ADDR) reg_wdata <= {1'b0, d[6:5], 1'b1, d[3:0]};
        else if (a == ARVC_SCALE_ADDR) reg_wdata <= {2'b00, d[5:0]};
        else reg_wdata <= d;
        @(posedge clk);
    endtask
    // drop both strobes for one cycle
    task automatic idle();
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    // read; data is taken inside the answer cycle, clear of the edge that ends it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_rd   <= 1'b1;
        reg_wr   <= 1'b0;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge clk);
    endtask
endmodule // arvc_host_model

// ==== bench/arvc_rate_scale_cfg_tb.sv ====
// self-checking bench for the rate and scale source register bank
`timescale 1ns/100ps
module arvc_rate_scale_cfg_tb;
    import arvc_pkg::*;
    typedef struct { logic [7:0] a; logic [7:0] d; logic [8:0] e; } arvc_row_s;
    logic       clk, sys_rst;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic       reg_wr, reg_rd, ext_clk_sel, single_shot, rate_code_valid, pos_buf_en;
    logic       neg_buf_en, scale_sel_valid, int_ref_on, int_ref_keep_pd;
    logic       int_ref_pwr_valid, buf_advice_viol;
    logic [3:0] output_rate_code;
    logic [1:0] scale_input_select;
    logic [8:0] rate_v, scale_v;
    int         miscompares = 0, checked = 0;
    // expected decoded levels worked out by hand for each written byte
    arvc_row_s  rows [8] = '{
        '{8'h04, 8'h50, 9'h041}, '{8'h04, 8'h3F, 9'h03E}, '{8'h04, 8'h7D, 9'h07B},
        '{8'h05, 8'h00, 9'h192}, '{8'h05, 8'h39, 9'h05A}, '{8'h05, 8'h1E, 9'h16E},
        '{8'h05, 8'h0B, 9'h1D1}, '{8'h05, 8'h14, 9'h132}};
    assign rate_v  = {2'b00, ext_clk_sel, single_shot, output_rate_code, rate_code_valid};
    assign scale_v = {pos_buf_en, neg_buf_en, scale_input_select, scale_sel_valid,
                      int_ref_on, int_ref_keep_pd, int_ref_pwr_valid, buf_advice_viol};
    arvc_rate_scale_cfg u_dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_clk_sel(ext_clk_sel), .single_shot(single_shot),
        .output_rate_code(output_rate_code), .rate_code_valid(rate_code_valid),
        .pos_buf_en(pos_buf_en), .neg_buf_en(neg_buf_en),
        .scale_input_select(scale_input_select), .scale_sel_valid(scale_sel_valid),
        .int_ref_on(int_ref_on), .int_ref_keep_pd(int_ref_keep_pd),
        .int_ref_pwr_valid(int_ref_pwr_valid), .buf_advice_viol(buf_advice_viol));
    arvc_host_model u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // reset values of both registers and of every decoded level
    task automatic reset_check();
        chk(rate_v, 9'h009);
        chk(scale_v, 9'h112);
        u_host.rd(8'h04, rv);
        chk({1'b0, rv}, 9'h014);
        u_host.rd(8'h05, rv);
        chk({1'b0, rv}, 9'h010);
    endtask
    // a hang ends the run as a failure
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        reset_check();
        // every row: write, settle, compare levels and read back
        foreach (rows[i]) begin
            u_host.wr(rows[i].a, rows[i].d);
            u_host.idle();
            chk(rows[i].a == 8'h04 ? rate_v : scale_v, rows[i].e);
            u_host.rd(rows[i].a, rv);
            chk({1'b0, rv}, {1'b0, rows[i].d});
        end
        // unmapped address leaves both registers alone and reads zero
        u_host.wr(8'h06, 8'hFF);
        u_host.rd(8'h06, rv);
        chk({1'b0, rv}, 9'h000);
        u_host.rd(8'h04, rv);
        chk({1'b0, rv}, 9'h07D);
        u_host.rd(8'h05, rv);
        chk({1'b0, rv}, 9'h014);
        // read with no gap after write sees the new byte
        u_host.wr(8'h04, 8'h52);
        u_host.rd(8'h04, rv);
        chk({1'b0, rv}, 9'h052);
        u_host.wr(8'h05, 8'h2A);
        u_host.rd(8'h05, rv);
        chk({1'b0, rv}, 9'h02A);
        // host powers the internal source before any excitation current use
        chk({8'h00, int_ref_on}, 9'h001);
        // second reset in mid-run restores defaults
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        reset_check();
        give_verdict();
    end
endmodule // arvc_rate_scale_cfg_tb

// ==== design/arvc_field_decode.sv ====
// field decoder: turns stored register bytes into control levels
`timescale 1ns/100ps
module arvc_field_decode
    import arvc_pkg::*;
(
    arvc_cfg_if.dec cfg     // register bytes in, control levels out
);
    // reserved codes decode to "not valid" but are never rewritten
    always_comb begin
        cfg.ext_clk_sel       = cfg.rate_reg[ARVC_CLK_SEL_BIT];
        cfg.single_shot       = cfg.rate_reg[ARVC_MODE_BIT];
        cfg.rate_code         = cfg.rate_reg[ARVC_RATE_MSB:ARVC_RATE_LSB];
        cfg.rate_code_valid   = (cfg.rate_code != ARVC_RATE_RESERVED);
        cfg.pos_buf_en        = ~cfg.scale_reg[ARVC_PBUF_BIT];
        cfg.neg_buf_en        = ~cfg.scale_reg[ARVC_NBUF_BIT];
        cfg.scale_sel         = cfg.scale_reg[ARVC_SEL_MSB:ARVC_SEL_LSB];
        cfg.scale_sel_valid   = (cfg.scale_sel != ARVC_SEL_RSV);
        cfg.int_ref_on        = (cfg.scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ON_PD)
                              | (cfg.scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ALWAYS);
        cfg.int_ref_keep_pd   = (cfg.scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ALWAYS);
        cfg.int_ref_pwr_valid = (cfg.scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] != ARVC_PWR_RSV);
    end
endmodule // arvc_field_decode

// ==== design/arvc_rate_scale_cfg.sv ====
// rate and scale source configuration register bank, top level
// Overview of operation
// - bit 6 of rate register picks internal oscillator (0) or external clock (1).
// - bit 5 of rate register picks continuous (0) or single-shot (1) conversion.
// - four-bit rate code selects 2.5 to 4000 SPS, resets to 20 SPS, 1111 reserved.
// - rate register at 04h resets to 14h; host keeps bit7 zero, bit4 one.
// - bit 5 of scale register disables the positive buffer when set, reset clear.
// - bit 4 of scale register disables the negative buffer when set, reset set.
// - select field picks pair 0, pair 1 or internal 2.5 V; 11 reserved.
// - power field: 00 off, 01 on but sleeps, 10 always on, 11 reserved.
// - scale register at 05h resets to 10h; host keeps bits 7 and 6 zero.
`timescale 1ns/100ps
module arvc_rate_scale_cfg
    import arvc_pkg::*;
(
    input  wire logic               clk,             // 25 MHz clock
    input  wire logic               sys_rst,         // sync reset, active high
    input  wire logic [ARVC_AW-1:0] reg_addr,        // register address
    input  wire logic [ARVC_DW-1:0] reg_wdata,       // write data
    input  wire logic               reg_wr,          // write strobe
    input  wire logic               reg_rd,          // read strobe
    output logic      [ARVC_DW-1:0] reg_rdata,       // read data, cycle after strobe
    output logic                    ext_clk_sel,     // conversions on external clock
    output logic                    single_shot,     // single-shot conversion mode
    output logic      [3:0]         output_rate_code,// selected output rate code
    output logic                    rate_code_valid, // rate code not reserved
    output logic                    pos_buf_en,      // positive scale buffer on
    output logic                    neg_buf_en,      // negative scale buffer on
    output logic      [1:0]         scale_input_select, // scale source select
    output logic                    scale_sel_valid, // select code not reserved
    output logic                    int_ref_on,      // internal source powered
    output logic                    int_ref_keep_pd, // stays on in power-down
    output logic                    int_ref_pwr_valid, // power code not reserved
    output logic                    buf_advice_viol  // buffers on with internal source
);
    logic [7:0] rate_reg;
    logic [7:0] scale_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    arvc_cfg_if cfg_bus ();

    // address match helper, shared by write and read paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // rate register: whole byte stored as written, reserved codes kept
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rate_reg <= ARVC_RATE_RST;
        end else if (reg_wr && hit(reg_addr, ARVC_RATE_ADDR)) begin
            rate_reg <= reg_wdata;
        end
    end

    // scale source register: reserved bits are not forced, host owns them
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scale_reg <= ARVC_SCALE_RST;
        end else if (reg_wr && hit(reg_addr, ARVC_SCALE_ADDR)) begin
            scale_reg <= reg_wdata;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_next = ARVC_ZERO;
        if (hit(reg_addr, ARVC_RATE_ADDR)) begin
            rdata_next = rate_reg;
        end else if (hit(reg_addr, ARVC_SCALE_ADDR)) begin
            rdata_next = scale_reg;
        end
    end

    // read data holds only in the cycle after the strobe
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_reg <= ARVC_ZERO;
        end else if (reg_rd) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= ARVC_ZERO;
        end
    end
    assign reg_rdata = rdata_reg;

    assign cfg_bus.rate_reg  = rate_reg;
    assign cfg_bus.scale_reg = scale_reg;

    arvc_field_decode u_dec (
        .cfg (cfg_bus)
    );

    // decoded control levels
    assign ext_clk_sel        = cfg_bus.ext_clk_sel;
    assign single_shot        = cfg_bus.single_shot;
    assign output_rate_code   = cfg_bus.rate_code;
    assign rate_code_valid    = cfg_bus.rate_code_valid;
    assign pos_buf_en         = cfg_bus.pos_buf_en;
    assign neg_buf_en         = cfg_bus.neg_buf_en;
    assign scale_input_select = cfg_bus.scale_sel;
    assign scale_sel_valid    = cfg_bus.scale_sel_valid;
    assign int_ref_on         = cfg_bus.int_ref_on;
    assign int_ref_keep_pd    = cfg_bus.int_ref_keep_pd;
    assign int_ref_pwr_valid  = cfg_bus.int_ref_pwr_valid;
    // advisory only: the device does not override the host's choice
    assign buf_advice_viol = (cfg_bus.scale_sel == ARVC_SEL_INTERNAL)
                           & (cfg_bus.pos_buf_en | cfg_bus.neg_buf_en);

    // checks next to the logic; the helpers below are read by the checks only
    logic       wr_rate_hit;  // write aimed at the rate register
    logic       wr_scale_hit; // write aimed at the scale register
    logic       addr_mapped;  // address names one of the two registers
    logic [1:0] wr_sel_code;  // select field of the write data
    logic [1:0] wr_pwr_code;  // power field of the write data
    assign wr_rate_hit  = reg_wr && hit(reg_addr, ARVC_RATE_ADDR);
    assign wr_scale_hit = reg_wr && hit(reg_addr, ARVC_SCALE_ADDR);
    assign addr_mapped  = hit(reg_addr, ARVC_RATE_ADDR) || hit(reg_addr, ARVC_SCALE_ADDR);
    assign wr_sel_code  = reg_wdata[ARVC_SEL_MSB:ARVC_SEL_LSB];
    assign wr_pwr_code  = reg_wdata[ARVC_PWR_MSB:ARVC_PWR_LSB];

    // one clock domain: all checks share clock and reset gate;
    // the reset checks switch the gate off, since they must look during reset
    default clocking arvc_cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // reset values of both bytes
    AST_RATE_RESET: assert property (disable iff (1'b0)
        sys_rst |=> rate_reg == ARVC_RATE_RST)
        else $error("rate register not at reset value");

    AST_SCALE_RESET: assert property (disable iff (1'b0)
        sys_rst |=> scale_reg == ARVC_SCALE_RST)
        else $error("scale register not at reset value");

    // read data is quiet right after reset
    AST_RST_RDATA: assert property (disable iff (1'b0)
        sys_rst |=> reg_rdata == ARVC_ZERO)
        else $error("read data not zero after reset");

    // conversions start on the internal oscillator, continuous
    AST_RST_CLK: assert property (disable iff (1'b0)
        sys_rst |=> !ext_clk_sel)
        else $error("clock select not internal after reset");

    AST_RST_MODE: assert property (disable iff (1'b0)
        sys_rst |=> !single_shot)
        else $error("mode not continuous after reset");

    // default rate code is the 20 SPS code and counts as valid
    AST_RST_CODE: assert property (disable iff (1'b0)
        sys_rst |=> output_rate_code == ARVC_RATE_RST[ARVC_RATE_MSB:ARVC_RATE_LSB]
            && rate_code_valid)
        else $error("rate code wrong after reset");

    // positive buffer starts on, negative buffer starts off
    AST_RST_PBUF: assert property (disable iff (1'b0)
        sys_rst |=> pos_buf_en)
        else $error("positive buffer off after reset");

    AST_RST_NBUF: assert property (disable iff (1'b0)
        sys_rst |=> !neg_buf_en)
        else $error("negative buffer on after reset");

    // first external pair selected, internal source off
    AST_RST_SEL: assert property (disable iff (1'b0)
        sys_rst |=> scale_input_select == ARVC_SEL_PAIR0 && scale_sel_valid)
        else $error("select wrong after reset");

    AST_RST_PWR: assert property (disable iff (1'b0)
        sys_rst |=> !int_ref_on && !int_ref_keep_pd
            && int_ref_pwr_valid)
        else $error("power levels wrong after reset");

    // every write lands verbatim, reserved bits included
    AST_RATE_WRITE: assert property (
        wr_rate_hit |=> rate_reg == $past(reg_wdata))
        else $error("rate write not stored verbatim");

    AST_SCALE_WRITE: assert property (
        wr_scale_hit |=> scale_reg == $past(reg_wdata))
        else $error("scale write not stored verbatim");

    // rate byte fields drive the conversion controls
    AST_CLK_SEL: assert property (
        wr_rate_hit |=> ext_clk_sel == $past(reg_wdata[ARVC_CLK_SEL_BIT]))
        else $error("clock source select wrong");

    AST_MODE: assert property (
        wr_rate_hit |=> single_shot == $past(reg_wdata[ARVC_MODE_BIT]))
        else $error("conversion mode wrong");

    AST_RATE_CODE: assert property (
        wr_rate_hit |=> output_rate_code == $past(reg_wdata[ARVC_RATE_MSB:ARVC_RATE_LSB])
            && rate_code_valid == ($past(reg_wdata[ARVC_RATE_MSB:ARVC_RATE_LSB])
            != ARVC_RATE_RESERVED))
        else $error("rate code wrong");

    // bypass bits are active high disables
    AST_BUFS: assert property (
        wr_scale_hit |=> pos_buf_en == !$past(reg_wdata[ARVC_PBUF_BIT])
            && neg_buf_en == !$past(reg_wdata[ARVC_NBUF_BIT]))
        else $error("buffer enables wrong");

    // select and power outputs track the stored byte at all times
    AST_SEL_PWR: assert property (
        scale_input_select == scale_reg[ARVC_SEL_MSB:ARVC_SEL_LSB]
            && int_ref_on == (scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ON_PD
            || scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ALWAYS)
            && int_ref_keep_pd == (scale_reg[ARVC_PWR_MSB:ARVC_PWR_LSB] == ARVC_PWR_ALWAYS))
        else $error("select or power decode wrong");

    // read data is the addressed byte, one cycle later
    AST_READ: assert property (
        reg_rd && !reg_wr && hit(reg_addr, ARVC_RATE_ADDR) |=> reg_rdata == $past(rate_reg))
        else $error("rate readback wrong");

    AST_SCALE_READ: assert property (
        reg_rd && !reg_wr && hit(reg_addr, ARVC_SCALE_ADDR) |=> reg_rdata == $past(scale_reg))
        else $error("scale readback wrong");

    // unmapped reads give zero, and so does every cycle without a read
    AST_UNMAPPED_READ: assert property (
        reg_rd && !addr_mapped |=> reg_rdata == ARVC_ZERO)
        else $error("unmapped read not zero");

    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == ARVC_ZERO)
        else $error("read data stands too long");

    // a read straight after a write returns the new byte
    AST_B2B_RATE: assert property (
        wr_rate_hit ##1 (reg_rd && !reg_wr && hit(reg_addr, ARVC_RATE_ADDR))
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("rate read after write stale");

    AST_B2B_SCALE: assert property (
        wr_scale_hit ##1 (reg_rd && !reg_wr && hit(reg_addr, ARVC_SCALE_ADDR))
            |=> reg_rdata == $past(reg_wdata, 2))
        else $error("scale read after write stale");

    // bytes move only on a write aimed at them; stray writes are ignored
    AST_RATE_HOLD: assert property (
        !wr_rate_hit |=> rate_reg == $past(rate_reg))
        else $error("rate register moved without write");

    AST_SCALE_HOLD: assert property (
        !wr_scale_hit |=> scale_reg == $past(scale_reg))
        else $error("scale register moved without write");

    AST_UNMAPPED_WRITE: assert property (
        reg_wr && !addr_mapped |=> rate_reg == $past(rate_reg)
            && scale_reg == $past(scale_reg))
        else $error("unmapped write changed a register");

    // controls stay put between writes, so conversions see no glitch
    AST_CLK_HOLD: assert property (
        !wr_rate_hit |=> $stable(ext_clk_sel) && $stable(single_shot)
            && $stable(output_rate_code))
        else $error("rate controls moved without write");

    AST_SCALE_OUT_HOLD: assert property (
        !wr_scale_hit |=> $stable(scale_input_select) && $stable(int_ref_on)
            && $stable(pos_buf_en) && $stable(neg_buf_en))
        else $error("scale controls moved without write");

    // reserved bits are kept as written, never forced to the advised level
    AST_RATE_RSV_KEPT: assert property (
        wr_rate_hit |=> rate_reg[ARVC_RATE_RSV7] == $past(reg_wdata[ARVC_RATE_RSV7])
            && rate_reg[ARVC_RATE_RSV4] == $past(reg_wdata[ARVC_RATE_RSV4]))
        else $error("rate reserved bits altered");

    AST_SCALE_RSV_KEPT: assert property (
        wr_scale_hit |=> scale_reg[ARVC_DW-1:ARVC_PBUF_BIT+1]
            == $past(reg_wdata[ARVC_DW-1:ARVC_PBUF_BIT+1]))
        else $error("scale reserved bits altered");

    // reserved codes are flagged, not rewritten
    AST_RATE_RSV_CODE: assert property (
        wr_rate_hit && reg_wdata[ARVC_RATE_MSB:ARVC_RATE_LSB] == ARVC_RATE_RESERVED
            |=> !rate_code_valid && output_rate_code == ARVC_RATE_RESERVED)
        else $error("reserved rate code mishandled");

    AST_SEL_RSV: assert property (
        wr_scale_hit && wr_sel_code == ARVC_SEL_RSV |=> !scale_sel_valid
            && scale_input_select == ARVC_SEL_RSV)
        else $error("reserved select code mishandled");

    AST_PWR_RSV: assert property (
        wr_scale_hit && wr_pwr_code == ARVC_PWR_RSV |=> !int_ref_pwr_valid
            && !int_ref_on && !int_ref_keep_pd)
        else $error("reserved power code mishandled");

    // each power code gives its own on and keep levels
    AST_PWR_OFF: assert property (
        wr_scale_hit && wr_pwr_code == ARVC_PWR_OFF |=> !int_ref_on
            && !int_ref_keep_pd && int_ref_pwr_valid)
        else $error("power off code wrong");

    AST_PWR_ON: assert property (
        wr_scale_hit && wr_pwr_code == ARVC_PWR_ON_PD |=> int_ref_on
            && !int_ref_keep_pd && int_ref_pwr_valid)
        else $error("power on code wrong");

    AST_PWR_KEEP: assert property (
        wr_scale_hit && wr_pwr_code == ARVC_PWR_ALWAYS |=> int_ref_on
            && int_ref_keep_pd && int_ref_pwr_valid)
        else $error("always on code wrong");

    // second pair and internal select codes reach the scale multiplexer unchanged
    AST_SEL_P1: assert property (
        wr_scale_hit && wr_sel_code == ARVC_SEL_PAIR1 |=>
            scale_input_select == ARVC_SEL_PAIR1 && scale_sel_valid)
        else $error("second pair select wrong");

    AST_SEL_INT: assert property (
        wr_scale_hit && wr_sel_code == ARVC_SEL_INTERNAL |=>
            scale_input_select == ARVC_SEL_INTERNAL && scale_sel_valid)
        else $error("internal select wrong");

    // advisory flag follows the host's buffer choice with the internal source
    AST_VIOL: assert property (
        wr_scale_hit && wr_sel_code == ARVC_SEL_INTERNAL
            && !(reg_wdata[ARVC_PBUF_BIT] && reg_wdata[ARVC_NBUF_BIT]) |=> buf_advice_viol)
        else $error("advisory flag missed");

    AST_NO_VIOL: assert property (
        wr_scale_hit && reg_wdata[ARVC_PBUF_BIT] && reg_wdata[ARVC_NBUF_BIT]
            |=> !buf_advice_viol)
        else $error("advisory flag false");

    // bit by bit: a write to one byte never disturbs a bit of the other
    for (genvar b = 0; b < ARVC_DW; b++) begin : g_bit_iso
        AST_RATE_BIT_ISO: assert property (
            wr_scale_hit |=> rate_reg[b] == $past(rate_reg[b]))
            else $error("rate bit changed by scale write");
        AST_SCALE_BIT_ISO: assert property (
            wr_rate_hit |=> scale_reg[b] == $past(scale_reg[b]))
            else $error("scale bit changed by rate write");
    end
endmodule // arvc_rate_scale_cfg

// ==== shared/arvc_cfg_if.sv ====
// register bytes passed from register bank to decoder, decoded fields passed back
`timescale 1ns/100ps
interface arvc_cfg_if;
    logic [7:0] rate_reg;
    logic [7:0] scale_reg;
    logic       ext_clk_sel;
    logic       single_shot;
    logic [3:0] rate_code;
    logic       rate_code_valid;
    logic       pos_buf_en;
    logic       neg_buf_en;
    logic [1:0] scale_sel;
    logic       scale_sel_valid;
    logic       int_ref_on;
    logic       int_ref_keep_pd;
    logic       int_ref_pwr_valid;
    modport regs (output rate_reg, output scale_reg,
                  input ext_clk_sel, input single_shot, input rate_code,
                  input rate_code_valid, input pos_buf_en, input neg_buf_en,
                  input scale_sel, input scale_sel_valid, input int_ref_on,
                  input int_ref_keep_pd, input int_ref_pwr_valid);
    modport dec (input rate_reg, input scale_reg,
                 output ext_clk_sel, output single_shot, output rate_code,
                 output rate_code_valid, output pos_buf_en, output neg_buf_en,
                 output scale_sel, output scale_sel_valid, output int_ref_on,
                 output int_ref_keep_pd, output int_ref_pwr_valid);
endinterface

// ==== shared/arvc_pkg.sv ====
// package for the rate and scale source configuration register bank
package arvc_pkg;
    localparam int ARVC_AW = 8;
    localparam int ARVC_DW = 8;
    // register offsets
    localparam logic [7:0] ARVC_RATE_ADDR  = 8'h04;
    localparam logic [7:0] ARVC_SCALE_ADDR = 8'h05;
    // reset values
    localparam logic [7:0] ARVC_RATE_RST   = 8'h14;
    localparam logic [7:0] ARVC_SCALE_RST  = 8'h10;
    // rate register fields
    localparam int ARVC_RATE_RSV7   = 7;
    localparam int ARVC_CLK_SEL_BIT = 6;
    localparam int ARVC_MODE_BIT    = 5;
    localparam int ARVC_RATE_RSV4   = 4;
    localparam int ARVC_RATE_MSB    = 3;
    localparam int ARVC_RATE_LSB    = 0;
    // scale register fields
    localparam int ARVC_PBUF_BIT    = 5;
    localparam int ARVC_NBUF_BIT    = 4;
    localparam int ARVC_SEL_MSB     = 3;
    localparam int ARVC_SEL_LSB     = 2;
    localparam int ARVC_PWR_MSB     = 1;
    localparam int ARVC_PWR_LSB     = 0;
    localparam logic [7:0] ARVC_ZERO = 8'h00;
    localparam logic [3:0] ARVC_RATE_RESERVED = 4'hf;
    // scale input selection codes
    typedef enum logic [1:0] {
        ARVC_SEL_PAIR0    = 2'b00,
        ARVC_SEL_PAIR1    = 2'b01,
        ARVC_SEL_INTERNAL = 2'b10,
        ARVC_SEL_RSV      = 2'b11
    } arvc_sel_e;
    // internal source power codes
    typedef enum logic [1:0] {
        ARVC_PWR_OFF      = 2'b00,
        ARVC_PWR_ON_PD    = 2'b01,
        ARVC_PWR_ALWAYS   = 2'b10,
        ARVC_PWR_RSV      = 2'b11
    } arvc_pwr_e;
endpackage
